// File: als_pkg.sv
/*
 * Shared constants, types and register layout for the light sensor core.
 * Assumes a 100 MHz APB clock and a same-clock light sample input.
 */
`default_nettype none

package als_pkg;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_RESULT = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_HIGH = 8'h0C;
  localparam logic [7:0] OFF_I2C_RX = 8'h10;
  localparam logic [7:0] OFF_I2C_TX = 8'h14;

  // ************************************************************
  // Configuration field positions
  // ************************************************************
  localparam int CFG_RANGE_POS = 12;
  localparam int CFG_CT_POS = 11;
  localparam int CFG_MODE_POS = 9;
  localparam int CFG_READY_POS = 7;
  localparam int CFG_FHIGH_POS = 6;
  localparam int CFG_FLOW_POS = 5;
  localparam int CFG_LATCH_POS = 4;
  localparam int CFG_POL_POS = 3;
  localparam int CFG_FC_POS = 0;

  // ************************************************************
  // Encodings and reset values
  // ************************************************************
  localparam logic [1:0] MODE_SHUTDOWN = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [3:0] RANGE_AUTO = 4'hC;
  localparam logic [3:0] RANGE_RST = 4'hC;
  localparam logic [3:0] RANGE_MAX = 4'hB;
  localparam logic [4:0] ADDR_BASE = 5'h11;
  localparam logic [15:0] LOW_RST = 16'h0000;
  localparam logic [15:0] HIGH_RST = 16'hFFFF;
  localparam logic [7:0] TX_RST = 8'h00;

  // ************************************************************
  // Times and derived cycle counts
  // ************************************************************
  localparam int unsigned CLK_KHZ = 100000;
  localparam int unsigned TIMEOUT_MS = 28;
  localparam int unsigned INTEG_SHORT_MS = 100;
  localparam int unsigned INTEG_LONG_MS = 800;
  localparam int unsigned CONV_EXTRA_MS = 3;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned CONV_SHORT_CYC =
    (INTEG_SHORT_MS + CONV_EXTRA_MS) * CLK_KHZ;
  localparam int unsigned CONV_LONG_CYC =
    (INTEG_LONG_MS + CONV_EXTRA_MS) * CLK_KHZ;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_RACK
  } als_i2c_st_t;

  typedef struct packed {
    logic [3:0] range_select;
    logic conversion_time_select;
    logic [1:0] mode;
    logic latch;
    logic interrupt_polarity;
    logic [1:0] fault_count;
  } als_cfg_t;

  typedef struct packed {
    logic flag_high;
    logic flag_low;
    logic conv_ready;
    logic int_active;
  } als_flags_t;

endpackage

`default_nettype wire

// File: als_core.sv
/*
 * Light sensor digital core: I2C slave, conversion timing, limit
 * comparison with fault counting, open-drain interrupt, APB registers.
 * Assumes SCL, SDA and the address strap are asynchronous pins and the
 * light sample comes from logic on pclk. SDA is an open-drain triple, INT an output and enable pair.
 */
// Behaviour
// - First byte after start holds seven address bits plus direction.
// - Address shifted in on SCL rise; matching address acked low on ninth.
// - Bytes are eight bits MSB first plus ack; SDA stable while SCL high.
// - SDA change while SCL high is a start or stop, never data.
// - SCL held low for 28 ms resets the bus state machine.
// - Strap ground/supply/SDA/SCL gives address 1000100/101/110/111.
// - Address strap is sampled afresh at every bus start.
// - Slave keeps up with SCL up to 2.6 MHz.
// - Power-up in shutdown; measuring only after an active mode is set.
// - Continuous and single-shot conversion, chosen over the bus.
// - Integration period is either 100 ms or 800 ms.
// - Conversion-time select of 1 picks the 800 ms period.
// - Range select 1100b turns on automatic range choice.
// - Each result is compared with high and low limits as fault events.
// - Flags and interrupt change only after fault count consecutive faults.
// - Latch select picks latched window or transparent hysteresis mode.
// - Interrupt pin is open drain: pulls low or releases only.
// - Polarity 0: pin pulled low while interrupt active.
// - Polarity 1: pin released while interrupt active.
// - Latched: pin and flags held until configuration read clears them.
// - Latch select at bit 4; 0 is transparent and ignores alert response.
// - Transparent: high sets high flag, activates; low sets low, releases.
// - Conversion lasts the integration time plus 3 ms.
`timescale 1ns/1ps
`default_nettype none

module als_core
  import als_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter int unsigned CONV_SHORT_CYCLES = CONV_SHORT_CYC,
  parameter int unsigned CONV_LONG_CYCLES = CONV_LONG_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // I2C pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen,
  input wire logic [1:0] addr_strap_i,
  // Measurement front end
  input wire logic [15:0] light_i,
  output logic [3:0] fsr_o,
  output logic conv_active_o,
  // Interrupt pin, open drain
  output logic int_o,
  output logic int_oen,
  // Received I2C byte strobe
  output logic rx_valid_o
);

  // ************************************************************
  // Parameter checks
  // ************************************************************
  if (TIMEOUT_CYCLES < 2 || CONV_SHORT_CYCLES < 2 ||
      CONV_LONG_CYCLES < 2) begin : g_chk
    $error("als_core: cycle counts must be at least 2");
  end

  // ************************************************************
  // Pin synchronisers and bus event detection
  // ************************************************************
  logic [1:0] scl_sy_r, sda_sy_r;
  logic [1:0] strap_a_r, strap_b_r;
  logic scl_d_r, sda_d_r;
  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      strap_a_r <= 2'h0;
      strap_b_r <= 2'h0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], scl_i};
      sda_sy_r <= {sda_sy_r[0], sda_i};
      strap_a_r <= addr_strap_i;
      strap_b_r <= strap_a_r;
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
    end
  end

  assign scl_s = scl_sy_r[1];
  assign sda_s = sda_sy_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // ************************************************************
  // SCL low timeout
  // ************************************************************
  als_i2c_st_t st_r;
  logic [31:0] tmo_cnt_r;
  logic tmo_hit;

  assign tmo_hit = (tmo_cnt_r == TIMEOUT_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt_r <= 32'h0;
    end else if (st_r == ST_IDLE || scl_s || tmo_hit) begin
      tmo_cnt_r <= 32'h0;
    end else begin
      tmo_cnt_r <= tmo_cnt_r + 32'h1;
    end
  end

  // ************************************************************
  // I2C slave state machine
  // ************************************************************
  logic [7:0] sh_r, rx_byte_r, tx_byte_r;
  logic [3:0] bit_cnt_r;
  logic [6:0] own_addr_r;
  logic rw_r, sda_oen_r, rx_valid_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      sh_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      own_addr_r <= 7'h00;
      rw_r <= 1'b0;
      sda_oen_r <= 1'b1;
      rx_byte_r <= 8'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (tmo_hit) begin
        st_r <= ST_IDLE;
        sda_oen_r <= 1'b1;
      end else if (bus_start) begin
        st_r <= ST_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oen_r <= 1'b1;
        own_addr_r <= {ADDR_BASE, strap_b_r};
      end else if (bus_stop) begin
        st_r <= ST_IDLE;
        sda_oen_r <= 1'b1;
      end else begin
        case (st_r)
          ST_ADDR, ST_WR: begin
            if (scl_rise) begin
              sh_r <= {sh_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              if (st_r == ST_WR) begin
                rx_byte_r <= sh_r;
                rx_valid_r <= 1'b1;
                st_r <= ST_ACK;
                sda_oen_r <= 1'b0;
              end else if (sh_r[7:1] == own_addr_r) begin
                rw_r <= sh_r[0];
                st_r <= ST_ACK;
                sda_oen_r <= 1'b0;
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                st_r <= ST_RD;
                sda_oen_r <= tx_byte_r[7];
                sh_r <= {tx_byte_r[6:0], 1'b0};
              end else begin
                st_r <= ST_WR;
                sda_oen_r <= 1'b1;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                st_r <= ST_RACK;
                sda_oen_r <= 1'b1;
              end else begin
                sda_oen_r <= sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st_r <= sda_s ? ST_IDLE : ST_ACK;
            end
          end
          default: begin
            st_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oen = sda_oen_r;
  assign rx_valid_o = rx_valid_r;

  // ************************************************************
  // APB decode
  // ************************************************************
  als_cfg_t cfg_r;
  als_flags_t flg_r;
  logic [15:0] result_r, low_r, high_r;
  logic [31:0] prdata_r;
  logic wr_acc, rd_acc, cfg_wr, cfg_rd, mapped;
  logic [31:0] rd_mux;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign cfg_wr = wr_acc & (paddr == OFF_CFG);
  assign cfg_rd = rd_acc & (paddr == OFF_CFG);
  assign mapped = (paddr == OFF_CFG) || (paddr == OFF_RESULT) ||
                  (paddr == OFF_LOW) || (paddr == OFF_HIGH) ||
                  (paddr == OFF_I2C_RX) || (paddr == OFF_I2C_TX);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_r;

  always_comb begin
    rd_mux = 32'h0;
    if (paddr == OFF_CFG) begin
      rd_mux[CFG_RANGE_POS +: 4] = cfg_r.range_select;
      rd_mux[CFG_CT_POS] = cfg_r.conversion_time_select;
      rd_mux[CFG_MODE_POS +: 2] = cfg_r.mode;
      rd_mux[CFG_READY_POS] = flg_r.conv_ready;
      rd_mux[CFG_FHIGH_POS] = flg_r.flag_high;
      rd_mux[CFG_FLOW_POS] = flg_r.flag_low;
      rd_mux[CFG_LATCH_POS] = cfg_r.latch;
      rd_mux[CFG_POL_POS] = cfg_r.interrupt_polarity;
      rd_mux[CFG_FC_POS +: 2] = cfg_r.fault_count;
    end else if (paddr == OFF_RESULT) begin
      rd_mux = {16'h0, result_r};
    end else if (paddr == OFF_LOW) begin
      rd_mux = {16'h0, low_r};
    end else if (paddr == OFF_HIGH) begin
      rd_mux = {16'h0, high_r};
    end else if (paddr == OFF_I2C_RX) begin
      rd_mux = {24'h0, rx_byte_r};
    end else if (paddr == OFF_I2C_TX) begin
      rd_mux = {24'h0, tx_byte_r};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_r <= LOW_RST;
      high_r <= HIGH_RST;
      tx_byte_r <= TX_RST;
    end else if (wr_acc) begin
      if (paddr == OFF_LOW) begin
        low_r <= pwdata[15:0];
      end else if (paddr == OFF_HIGH) begin
        high_r <= pwdata[15:0];
      end else if (paddr == OFF_I2C_TX) begin
        tx_byte_r <= pwdata[7:0];
      end
    end
  end

  // ************************************************************
  // Conversion timing and mode control
  // ************************************************************
  logic [31:0] conv_cnt_r, conv_len;
  logic conv_busy_r, conv_done;

  assign conv_len = cfg_r.conversion_time_select ?
    CONV_LONG_CYCLES : CONV_SHORT_CYCLES;
  assign conv_done = conv_busy_r && (conv_cnt_r == conv_len - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= '{range_select: RANGE_RST, conversion_time_select: 1'b1,
                 mode: MODE_SHUTDOWN, latch: 1'b1,
                 interrupt_polarity: 1'b0, fault_count: 2'h0};
    end else if (cfg_wr) begin
      cfg_r.range_select <= pwdata[CFG_RANGE_POS +: 4];
      cfg_r.conversion_time_select <= pwdata[CFG_CT_POS];
      cfg_r.mode <= pwdata[CFG_MODE_POS +: 2];
      cfg_r.latch <= pwdata[CFG_LATCH_POS];
      cfg_r.interrupt_polarity <= pwdata[CFG_POL_POS];
      cfg_r.fault_count <= pwdata[CFG_FC_POS +: 2];
    end else if (conv_done && cfg_r.mode == MODE_SINGLE) begin
      cfg_r.mode <= MODE_SHUTDOWN;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_busy_r <= 1'b0;
      conv_cnt_r <= 32'h0;
    end else if (cfg_r.mode == MODE_SHUTDOWN || conv_done) begin
      conv_busy_r <= 1'b0;
      conv_cnt_r <= 32'h0;
    end else begin
      conv_busy_r <= 1'b1;
      conv_cnt_r <= conv_busy_r ? conv_cnt_r + 32'h1 : 32'h0;
    end
  end

  assign conv_active_o = conv_busy_r;

  // ************************************************************
  // Result capture and automatic range
  // ************************************************************
  logic [3:0] fsr_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r <= 16'h0000;
      fsr_r <= 4'h0;
    end else begin
      if (conv_done) begin
        result_r <= light_i;
      end
      if (cfg_r.range_select != RANGE_AUTO) begin
        fsr_r <= cfg_r.range_select;
      end else if (conv_done) begin
        if (light_i[15:14] == 2'h3 && fsr_r < RANGE_MAX) begin
          fsr_r <= fsr_r + 4'h1;
        end else if (light_i[15:12] == 4'h0 && fsr_r != 4'h0) begin
          fsr_r <= fsr_r - 4'h1;
        end
      end
    end
  end

  assign fsr_o = fsr_r;

  // ************************************************************
  // Fault counting and interrupt reporting
  // ************************************************************
  logic [3:0] cnt_hi_r, cnt_lo_r, need;
  logic hi_evt, lo_evt, trig_hi, trig_lo, int_oen_r;

  assign hi_evt = light_i > high_r;
  assign lo_evt = light_i < low_r;
  assign need = 4'h1 << cfg_r.fault_count;
  assign trig_hi = conv_done && hi_evt && (cnt_hi_r + 4'h1 >= need);
  assign trig_lo = conv_done && lo_evt && (cnt_lo_r + 4'h1 >= need);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_hi_r <= 4'h0;
      cnt_lo_r <= 4'h0;
    end else if (conv_done) begin
      cnt_hi_r <= !hi_evt ? 4'h0 : (cnt_hi_r < need ? cnt_hi_r + 4'h1 : need);
      cnt_lo_r <= !lo_evt ? 4'h0 : (cnt_lo_r < need ? cnt_lo_r + 4'h1 : need);
    end
  end

  // Clears are applied first so a same-cycle set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flg_r <= '0;
    end else begin
      if (cfg_rd) begin
        flg_r.conv_ready <= 1'b0;
        if (cfg_r.latch) begin
          flg_r.flag_high <= 1'b0;
          flg_r.flag_low <= 1'b0;
          flg_r.int_active <= 1'b0;
        end
      end
      if (cfg_wr && pwdata[CFG_MODE_POS +: 2] != MODE_SHUTDOWN) begin
        flg_r.conv_ready <= 1'b0;
      end
      if (conv_done) begin
        flg_r.conv_ready <= 1'b1;
      end
      if (cfg_r.latch) begin
        if (trig_hi) begin
          flg_r.flag_high <= 1'b1;
          flg_r.int_active <= 1'b1;
        end
        if (trig_lo) begin
          flg_r.flag_low <= 1'b1;
          flg_r.int_active <= 1'b1;
        end
      end else if (trig_hi) begin
        flg_r.flag_high <= 1'b1;
        flg_r.flag_low <= 1'b0;
        flg_r.int_active <= 1'b1;
      end else if (trig_lo) begin
        flg_r.flag_low <= 1'b1;
        flg_r.flag_high <= 1'b0;
        flg_r.int_active <= 1'b0;
      end
    end
  end

  // Release when active only under polarity 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_oen_r <= 1'b0;
    end else begin
      int_oen_r <= cfg_r.interrupt_polarity ? ~flg_r.int_active :
                   flg_r.int_active;
    end
  end

  assign int_o = 1'b0;
  assign int_oen = ~int_oen_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_addr_hit;
    st_r == ST_ADDR && scl_fall && bit_cnt_r == 4'h8 &&
      sh_r[7:1] == own_addr_r && !tmo_hit && !bus_start && !bus_stop;
  endsequence

  property p_addr_ack;
    @(posedge pclk) disable iff (!presetn)
      s_addr_hit |=> (st_r == ST_ACK && !sda_oen);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("matched address not acknowledged");

  property p_start_addr;
    @(posedge pclk) disable iff (!presetn)
      (bus_start && !tmo_hit) |=> (st_r == ST_ADDR && bit_cnt_r == 4'h0);
  endproperty
  a_start_addr: assert property (p_start_addr)
    else $error("start condition not taken");

  property p_timeout;
    @(posedge pclk) disable iff (!presetn)
      tmo_hit |=> (st_r == ST_IDLE && sda_oen);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("bus timeout did not reset slave");

  property p_own_addr;
    @(posedge pclk) disable iff (!presetn)
      (bus_start && !tmo_hit) |=>
        own_addr_r == {ADDR_BASE, $past(strap_b_r)};
  endproperty
  a_own_addr: assert property (p_own_addr)
    else $error("slave address not taken from strap");

  property p_shutdown_idle;
    @(posedge pclk) disable iff (!presetn)
      (cfg_r.mode == MODE_SHUTDOWN) |=> !conv_busy_r;
  endproperty
  a_shutdown_idle: assert property (p_shutdown_idle)
    else $error("conversion running in shutdown");

  property p_single_stop;
    @(posedge pclk) disable iff (!presetn)
      (conv_done && cfg_r.mode == MODE_SINGLE && !cfg_wr) |=>
        (cfg_r.mode == MODE_SHUTDOWN && !conv_busy_r);
  endproperty
  a_single_stop: assert property (p_single_stop)
    else $error("single shot did not return to shutdown");

  property p_int_pin;
    @(posedge pclk) disable iff (!presetn)
      int_oen == !$past(cfg_r.interrupt_polarity ^ flg_r.int_active);
  endproperty
  a_int_pin: assert property (p_int_pin)
    else $error("interrupt pin level wrong for polarity");

  property p_latch_clear;
    @(posedge pclk) disable iff (!presetn)
      (cfg_rd && cfg_r.latch && !trig_hi && !trig_lo) |=>
        (!flg_r.flag_high && !flg_r.flag_low ##1
         int_oen != $past(cfg_r.interrupt_polarity));
  endproperty
  a_latch_clear: assert property (p_latch_clear)
    else $error("configuration read did not clear latch");

  property p_transp_high;
    @(posedge pclk) disable iff (!presetn)
      (trig_hi && !cfg_r.latch) |=>
        (flg_r.flag_high && !flg_r.flag_low && flg_r.int_active);
  endproperty
  a_transp_high: assert property (p_transp_high)
    else $error("transparent high trigger wrong");

endmodule

`default_nettype wire

// File: als_mst.sv
/* I2C bus master model for the light sensor bench.
   Assumes the bench resolves SDA from both open-drain drivers. */
`timescale 1ns/1ps
`default_nettype none
module als_mst (
  // Bus lines
  output logic scl,
  output logic sda_drv,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // ************************************
  // Framing, 80 ns bit period
  // ************************************
  task automatic start();
    #10 sda_drv = 1'b1;
    #30 scl = 1'b1;
    #40 sda_drv = 1'b0;
    #40 scl = 1'b0;
  endtask
  task automatic put_bit(input logic b, output logic r);
    #10 sda_drv = b;
    #30 scl = 1'b1;
    #20 r = sda;
    #20 scl = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], r);
    end
    put_bit(1'b1, ack);
  endtask
  task automatic stop();
    #10 sda_drv = 1'b0;
    #30 scl = 1'b1;
    #40 sda_drv = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb_light_sensor_i2c_interrupt.sv
/* Self-checking bench for the light sensor core.
   Assumes shortened timeout and conversion counts set below. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_light_sensor_i2c_interrupt;
  import als_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] v; logic e;} als_reg_t;
  typedef struct {logic [15:0] cfg; logic [15:0] lt; int len;
    logic oen; logic [1:0] flg; logic oen2;} als_conv_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic scl, sda_drv, sda, sda_o, sda_oen, int_o, int_oen, conv_act, rxv;
  logic [1:0] strap;
  logic [15:0] light;
  logic [3:0] fsr;
  logic err, ack;
  int n;
  int rx_cnt = 0;
  int num_errors = 0;
  int tests_run = 0;
  als_reg_t regs[5] = '{'{OFF_CFG, 32'h0000C810, 1'b0},
    '{OFF_LOW, 32'h0, 1'b0}, '{OFF_HIGH, 32'h0000FFFF, 1'b0},
    '{OFF_I2C_TX, 32'h0, 1'b0}, '{8'h18, 32'h0, 1'b1}};
  als_conv_t cv[5] = '{'{16'hC200, 16'h2000, 50, 1'b0, 2'b10, 1'b0},
    '{16'hCA00, 16'h0010, 90, 1'b1, 2'b01, 1'b1},
    '{16'hC208, 16'h2000, 50, 1'b1, 2'b10, 1'b1},
    '{16'hC210, 16'h2000, 50, 1'b0, 2'b10, 1'b1},
    '{16'hC211, 16'h0010, 50, 1'b1, 2'b00, 1'b1}};
  assign sda = sda_drv & (sda_oen | sda_o);
  als_core #(.TIMEOUT_CYCLES(200), .CONV_SHORT_CYCLES(50),
    .CONV_LONG_CYCLES(90)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oen(sda_oen),
    .addr_strap_i(strap), .light_i(light), .fsr_o(fsr),
    .conv_active_o(conv_act), .int_o(int_o), .int_oen(int_oen),
    .rx_valid_o(rxv));
  als_mst mst (.scl(scl), .sda_drv(sda_drv), .sda(sda));
  always @(posedge pclk) if (rxv === 1'b1) rx_cnt++;
  // ************************************
  // Clock, bus cycle and verdict
  // ************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_done();
    if (num_errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    num_errors++;
    test_done();
  end
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    strap = 2'h0;
    light = 16'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("conv_idle", 1'b0, conv_act)
    `CHK("od_low", 2'h0, {int_o, sda_o})
    `CHK("int_idle", 1'b1, int_oen)
    foreach (regs[i]) begin
      apb(1'b0, regs[i].a, 32'h0);
      `CHK("reg", {regs[i].e, regs[i].v}, {err, rd})
    end
    for (int s = 0; s < 4; s++) begin
      strap <= s[1:0];
      @(posedge pclk);
      #3;
      mst.start();
      mst.put_byte({5'b10001, s[1:0], 1'b0}, ack);
      `CHK("addr_ack", 1'b0, ack)
      mst.put_byte(8'hA5 ^ 8'(s), ack);
      `CHK("data_ack", 1'b0, ack)
      mst.stop();
      mst.start();
      mst.put_byte({5'b10001, s[1:0] ^ 2'h1, 1'b0}, ack);
      `CHK("foreign_ack", 1'b1, ack)
      mst.stop();
      @(posedge pclk);
      apb(1'b0, OFF_I2C_RX, 32'h0);
      `CHK("rx_byte", {24'h0, 8'hA5 ^ 8'(s)}, rd)
    end
    `CHK("rx_count", 4, rx_cnt)
    b = {5'b10001, 2'h3, 1'b0};
    @(posedge pclk);
    #3;
    mst.start();
    for (int i = 7; i >= 0; i--) mst.put_bit(b[i], ack);
    repeat (100) @(posedge pclk);
    `CHK("ack_held", 1'b0, sda_oen)
    repeat (150) @(posedge pclk);
    `CHK("bus_reset", 1'b1, sda_oen)
    mst.stop();
    @(posedge pclk);
    apb(1'b1, OFF_LOW, 32'h0100);
    apb(1'b1, OFF_HIGH, 32'h1000);
    foreach (cv[i]) begin
      light <= cv[i].lt;
      apb(1'b1, OFF_CFG, {16'h0, cv[i].cfg});
      @(posedge pclk);
      `CHK("conv_run", 1'b1, conv_act)
      n = 0;
      while (conv_act === 1'b1 && n < 200) begin
        @(posedge pclk);
        n++;
      end
      `CHK("conv_len", cv[i].len, n)
      repeat (3) @(posedge pclk);
      `CHK("int_pin", cv[i].oen, int_oen)
      apb(1'b0, OFF_CFG, 32'h0);
      `CHK("flags", cv[i].flg, rd[6:5])
      repeat (3) @(posedge pclk);
      `CHK("int_after_read", cv[i].oen2, int_oen)
    end
    light <= 16'hC000;
    apb(1'b1, OFF_CFG, 32'h0000C400);
    repeat (120) @(posedge pclk);
    `CHK("continuous", 1'b1, conv_act)
    `CHK("auto_range", 4'h2, fsr)
    apb(1'b1, OFF_CFG, 32'h0000C000);
    `CHK("int_before_rst", 1'b0, int_oen)
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK("rst_int", 1'b1, int_oen)
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFF_CFG, 32'h0);
    `CHK("rst_cfg", 32'h0000C810, rd)
    test_done();
  end
endmodule
`default_nettype wire
